// ==== design/timer_gate_top.sv ====
// timer with gate control, wishbone classic slave and one interrupt line
// assumes gate_i synchronous to clk_i; por_i pulses on power-on / brown-out,
// rst_i is any other reset and leaves the gate configuration untouched
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps

module timer_gate_top
  import timer_gate_pkg::*;
(
  // clock and resets
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               por_i,
  // wishbone classic slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic [31:0]             dat_o,
  output logic                    ack_o,
  // gate and timer
  input  wire logic               gate_i,
  output logic [COUNT_W-1:0]      count_o,
  output logic                    counting_o,
  // interrupt
  output logic                    irq_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  gate_ctrl_type      ctrl_r;
  gate_ctrl_type      ctrl_nxt;
  logic               timer_on_r;
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic               counting_r;
  logic [IRQ_W-1:0]   irq_stat_r;
  logic [IRQ_W-1:0]   irq_stat_nxt;
  logic [IRQ_W-1:0]   irq_mask_r;
  logic               irq_r;
  logic               ack_r;
  logic [31:0]        dat_r;
  logic [31:0]        rd_data;
  logic               gate_eff;
  logic               armed;
  logic               sp_done;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  wire req      = cyc_i & stb_i & ~ack_r;
  wire wr       = req & we_i;
  wire wr_b0    = wr & sel_i[0];
  wire wr_gate  = wr_b0 & hit(adr_i, GATE_CTRL_OFS);
  wire wr_tctl  = wr_b0 & hit(adr_i, TIMER_CTRL_OFS);
  wire wr_cnt_l = wr_b0 & hit(adr_i, COUNT_OFS);
  wire wr_cnt_h = wr & sel_i[1] & hit(adr_i, COUNT_OFS);
  wire wr_istat = wr_b0 & hit(adr_i, IRQ_STAT_OFS);
  wire wr_imask = wr_b0 & hit(adr_i, IRQ_MASK_OFS);

  // bits 1..0 are never stored
  assign ctrl_nxt = wr_gate ? {dat_i[GATE_ENABLE_BIT], dat_i[GATE_POLARITY_BIT],
                               dat_i[GATE_TOGGLE_BIT], dat_i[GATE_SPM_BIT]}
                            : ctrl_r;

  // arming only takes while single-pulse mode is (being) set
  wire arm    = wr_gate & dat_i[SP_ARM_BIT] & ctrl_nxt.single_pulse;
  wire cancel = wr_gate & ~dat_i[SP_ARM_BIT];

  // ----------------------------------------------------------------
  // gate path
  // ----------------------------------------------------------------
  gate_path u_gate_path (
    .clk_i    (clk_i),
    .por_i    (por_i),
    .ctrl_i   (ctrl_r),
    .arm_i    (arm),
    .cancel_i (cancel),
    .gate_i   (gate_i),
    .gate_o   (gate_eff),
    .armed_o  (armed),
    .done_o   (sp_done)
  );

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  wire count_en = timer_on_r & (~ctrl_r.enable | gate_eff);
  wire overflow = count_en & (count_r == COUNT_MAX);

  assign count_nxt = count_en ? count_r + 16'h0001 : count_r;

  // ----------------------------------------------------------------
  // interrupt status: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  wire [IRQ_W-1:0] irq_set = {overflow, sp_done};
  wire [IRQ_W-1:0] irq_clr = wr_istat ? dat_i[IRQ_W-1:0] : IRQ_RST;

  assign irq_stat_nxt = irq_set | (irq_stat_r & ~irq_clr);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0] gate_rd = {ctrl_r.enable, ctrl_r.polarity, ctrl_r.toggle,
                        ctrl_r.single_pulse, armed, gate_eff, 2'b00};

  always_comb
  begin
    rd_data = DAT_ZERO;
    case (adr_i)
      GATE_CTRL_OFS:  rd_data[7:0]         = gate_rd;
      TIMER_CTRL_OFS: rd_data[TIMER_ON_BIT] = timer_on_r;
      COUNT_OFS:      rd_data[COUNT_W-1:0] = count_r;
      IRQ_STAT_OFS:   rd_data[IRQ_W-1:0]   = irq_stat_r;
      IRQ_MASK_OFS:   rd_data[IRQ_W-1:0]   = irq_mask_r;
      default:        rd_data = DAT_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // gate configuration: cleared only by power-on / brown-out
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (por_i)
      ctrl_r <= GATE_CTRL_RST;
    else
      ctrl_r <= ctrl_nxt;
  end

  // ----------------------------------------------------------------
  // timer control and count
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || por_i)
    begin
      timer_on_r <= 1'b0;
      count_r    <= COUNT_RST;
      counting_r <= 1'b0;
    end
    else
    begin
      if (wr_tctl)
        timer_on_r <= dat_i[TIMER_ON_BIT];
      count_r[7:0]  <= wr_cnt_l ? dat_i[7:0]  : count_nxt[7:0];
      count_r[15:8] <= wr_cnt_h ? dat_i[15:8] : count_nxt[15:8];
      counting_r    <= count_en;
    end
  end

  // ----------------------------------------------------------------
  // interrupt registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || por_i)
    begin
      irq_stat_r <= IRQ_RST;
      irq_mask_r <= IRQ_RST;
      irq_r      <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_imask)
        irq_mask_r <= dat_i[IRQ_W-1:0];
      irq_r <= |(irq_stat_nxt & (wr_imask ? dat_i[IRQ_W-1:0] : irq_mask_r));
    end
  end

  // ----------------------------------------------------------------
  // bus answer: one wait state, unmapped reads return zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || por_i)
    begin
      ack_r <= 1'b0;
      dat_r <= DAT_ZERO;
    end
    else
    begin
      ack_r <= req;
      dat_r <= req ? rd_data : DAT_ZERO;
    end
  end

  assign ack_o      = ack_r;
  assign dat_o      = dat_r;
  assign count_o    = count_r;
  assign counting_o = counting_r;
  assign irq_o      = irq_r;

endmodule // timer_gate_top

// ==== design/timer_gate_pkg.sv ====
// timer gate control package: register map, field positions, reset values, types
// assumes a 32-bit classic wishbone register bus with word-aligned byte addresses
package timer_gate_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] GATE_CTRL_OFS  = 8'h00;
  localparam logic [7:0] TIMER_CTRL_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS      = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS   = 8'h10;

  // ----------------------------------------------------------------
  // gate control field positions
  // ----------------------------------------------------------------
  localparam int GATE_ENABLE_BIT   = 7;
  localparam int GATE_POLARITY_BIT = 6;
  localparam int GATE_TOGGLE_BIT   = 5;
  localparam int GATE_SPM_BIT      = 4;
  localparam int SP_ARM_BIT        = 3;
  localparam int GATE_LEVEL_BIT    = 2;

  // ----------------------------------------------------------------
  // other fields and reset values
  // ----------------------------------------------------------------
  localparam int TIMER_ON_BIT      = 0;
  localparam int IRQ_DONE_BIT      = 0;
  localparam int IRQ_OVF_BIT       = 1;
  localparam int IRQ_W             = 2;
  localparam int COUNT_W           = 16;
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [IRQ_W-1:0]   IRQ_RST   = 2'h0;
  localparam logic [31:0]        DAT_ZERO  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic polarity;
    logic toggle;
    logic single_pulse;
  } gate_ctrl_type;

  localparam gate_ctrl_type GATE_CTRL_RST = 4'h0;

  // gray along idle -> wait -> pulse; pulse -> idle flips both bits
  typedef enum logic [1:0] {
    SP_IDLE  = 2'b00,
    SP_WAIT  = 2'b01,
    SP_PULSE = 2'b11
  } sp_state_type;

endpackage

// ==== design/gate_path.sv ====
// gate signal path: polarity, toggle flip-flop and single-pulse acquisition
// assumes gate_i is synchronous to clk_i; por_i is the power-on / brown-out reset
`timescale 1ns/1ps
module gate_path
  import timer_gate_pkg::*;
(
  // clock and power-on reset
  input  wire logic          clk_i,
  input  wire logic          por_i,
  // configuration
  input  wire gate_ctrl_type ctrl_i,
  input  wire logic          arm_i,
  input  wire logic          cancel_i,
  // gate in, results out
  input  wire logic          gate_i,
  output logic               gate_o,
  output logic               armed_o,
  output logic               done_o
);

  logic         gate_prev_r;
  logic         toggle_r;
  logic         toggle_nxt;
  logic         pol_prev_r;
  sp_state_type sp_r;
  sp_state_type sp_nxt;
  logic         gate_r;
  logic         done_r;

  // ----------------------------------------------------------------
  // combinational path
  // ----------------------------------------------------------------
  wire gate_rise = gate_i & ~gate_prev_r;
  wire pol_level = ctrl_i.polarity ? gate_i : ~gate_i;
  // toggle flip-flop forced clear while toggle mode is off
  assign toggle_nxt = ~ctrl_i.toggle ? 1'b0 : (gate_rise ? ~toggle_r : toggle_r);
  wire tog_level = ctrl_i.toggle ? toggle_nxt : pol_level;
  wire act_rise  = tog_level & ~pol_prev_r;
  wire act_fall  = ~tog_level & pol_prev_r;

  always_comb
  begin
    sp_nxt = sp_r;
    case (sp_r)
      SP_IDLE:  sp_nxt = arm_i ? SP_WAIT : SP_IDLE;
      SP_WAIT:  sp_nxt = act_rise ? SP_PULSE : SP_WAIT;
      SP_PULSE: sp_nxt = (act_fall && !arm_i) ? SP_IDLE : SP_PULSE;
      default:  sp_nxt = SP_IDLE;
    endcase
    // a write that sets the mode and arms at once must not be lost to the old mode bit
    if (!arm_i && (!ctrl_i.single_pulse || cancel_i))
      sp_nxt = SP_IDLE;
  end

  wire sp_done  = ctrl_i.single_pulse && (sp_r == SP_PULSE) && act_fall && !arm_i;
  wire gate_nxt = ctrl_i.single_pulse ? (tog_level && (sp_nxt == SP_PULSE)) : tog_level;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      gate_prev_r <= 1'b0;
      toggle_r    <= 1'b0;
      pol_prev_r  <= 1'b0;
      sp_r        <= SP_IDLE;
      gate_r      <= 1'b0;
      done_r      <= 1'b0;
    end
    else
    begin
      gate_prev_r <= gate_i;
      toggle_r    <= toggle_nxt;
      pol_prev_r  <= tog_level;
      sp_r        <= sp_nxt;
      gate_r      <= gate_nxt;
      done_r      <= sp_done;
    end
  end

  assign gate_o  = gate_r;
  assign armed_o = (sp_r != SP_IDLE);
  assign done_o  = done_r;

endmodule // gate_path

// ==== dv/timer_gate_properties.sv ====
// checker for timer_gate_top: bus handshake, gating and interrupt relations
// sees only top ports; keeps shadows of the config from bus writes
`timescale 1ns/1ps
module timer_gate_properties
  import timer_gate_pkg::*;
(
  // clock and resets
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               por_i,
  // wishbone
  input wire logic               cyc_i,
  input wire logic               stb_i,
  input wire logic               we_i,
  input wire logic [7:0]         adr_i,
  input wire logic [3:0]         sel_i,
  input wire logic [31:0]        dat_i,
  input wire logic [31:0]        dat_o,
  input wire logic               ack_o,
  // gate, timer, interrupt
  input wire logic               gate_i,
  input wire logic [COUNT_W-1:0] count_o,
  input wire logic               counting_o,
  input wire logic               irq_o
);
  logic             wr;
  logic             wr_cnt;
  logic             cfg;
  logic [7:0]       gc_r;
  logic             ton_r;
  logic [IRQ_W-1:0] msk_r;
  assign wr  = cyc_i & stb_i & ~ack_o & we_i & sel_i[0];
  assign cfg = ton_r & gc_r[7] & ~gc_r[5] & ~gc_r[4];
  // lane 0 or lane 1 may write the count, so no lane is checked here
  assign wr_cnt = cyc_i & stb_i & ~ack_o & we_i & (adr_i == COUNT_OFS);
  // config survives rst_i, only por_i clears it
  always_ff @(posedge clk_i)
  begin
    if (por_i)
      gc_r <= 8'h00;
    else if (wr && adr_i == GATE_CTRL_OFS)
      gc_r <= dat_i[7:0];
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || por_i)
    begin
      ton_r <= 1'b0;
      msk_r <= IRQ_RST;
    end
    else if (wr)
    begin
      ton_r <= (adr_i == TIMER_CTRL_OFS) ? dat_i[TIMER_ON_BIT] : ton_r;
      msk_r <= (adr_i == IRQ_MASK_OFS) ? dat_i[IRQ_W-1:0] : msk_r;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);
  AST_ACK_REQ: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged next cycle");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  AST_DAT_IDLE: assert property (!ack_o |-> dat_o == DAT_ZERO)
    else $error("read data not zero outside ack");
  AST_UNIMPL: assert property (ack_o && $past(adr_i) == GATE_CTRL_OFS |-> dat_o[1:0] == 2'h0)
    else $error("low control bits not zero");
  AST_FREE_RUN: assert property (ton_r && !gc_r[7] |=> counting_o)
    else $error("timer not counting with gate disabled");
  AST_HOLD_OFF: assert property (!ton_r && !wr_cnt |=> $stable(count_o))
    else $error("count moved while timer off");
  AST_GATE_ON: assert property (cfg && gate_i == gc_r[6] ##1 cfg |=> counting_o)
    else $error("no count with gate active");
  AST_GATE_OFF: assert property (cfg && gate_i != gc_r[6] ##1 cfg |=> !counting_o)
    else $error("count with gate inactive");
  AST_IRQ_MASK: assert property (msk_r == IRQ_RST |-> !irq_o)
    else $error("interrupt with all sources masked");
  cover property (ack_o && $past(we_i));
  cover property (counting_o && gc_r[4]);
  cover property (irq_o);
endmodule // timer_gate_properties

bind timer_gate_top timer_gate_properties timer_gate_properties_inst (.*);

// ==== dv/gate_src.sv ====
// gate signal source for the timer gate bench
// level synchronous to clk_i, changed just after a rising edge
`timescale 1ns/1ps
module gate_src
(
  // clock
  input  wire logic clk_i,
  // gate out
  output logic      gate_o
);
  initial gate_o = 1'b0;
  task automatic set(input logic lvl);
    @(posedge clk_i);
    gate_o <= lvl;
  endtask
  // high for n cycles; n sets a prompt or slow pulse
  task automatic pulse(input int n);
    set(1'b1);
    repeat (n) @(posedge clk_i);
    gate_o <= 1'b0;
  endtask
endmodule // gate_src

// ==== dv/timer_gate_top_tb.sv ====
// self-checking bench for timer_gate_top
// one 100 MHz clock; wishbone master tasks and a gate source
`timescale 1ns/1ps
module timer_gate_top_tb
  import timer_gate_pkg::*;
();
  logic               clk_i;
  logic               rst_i;
  logic               por_i;
  logic               cyc_i;
  logic               stb_i;
  logic               we_i;
  logic               gate_i;
  logic               ack_o;
  logic               counting_o;
  logic               irq_o;
  logic [7:0]         adr_i;
  logic [3:0]         sel_i;
  logic [31:0]        dat_i;
  logic [31:0]        dat_o;
  logic [31:0]        q;
  logic [COUNT_W-1:0] count_o;
  logic [COUNT_W-1:0] c0;
  int                 n_fail = 0;
  int                 cmp_count = 0;
  timer_gate_top timer_gate_top_inst (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .gate_i(gate_i), .count_o(count_o), .counting_o(counting_o), .irq_o(irq_o));
  gate_src gate_src_inst (.clk_i(clk_i), .gate_o(gate_i));
  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // waits for ack with no limit of its own; the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic delta(input logic [COUNT_W-1:0] exp);
    repeat (4) @(posedge clk_i);
    chk({16'h0000, count_o - c0}, {16'h0000, exp});
  endtask
  // ----
  // scenarios
  // ----
  task automatic s_regs;
    bus(1'b0, GATE_CTRL_OFS, DAT_ZERO);
    chk(q & 32'hFFFF_FFFB, DAT_ZERO);
    bus(1'b1, GATE_CTRL_OFS, 32'h0000_00E3);
    bus(1'b0, GATE_CTRL_OFS, DAT_ZERO);
    chk(q & 32'hFFFF_FFFB, 32'h0000_00E0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, GATE_CTRL_OFS, DAT_ZERO);
    chk(q & 32'hFFFF_FFFB, 32'h0000_00E0);
    bus(1'b0, 8'h20, DAT_ZERO);
    chk(q, DAT_ZERO);
  endtask
  task automatic s_free;
    bus(1'b1, TIMER_CTRL_OFS, 32'h0000_0001);
    bus(1'b1, GATE_CTRL_OFS, DAT_ZERO);
    c0 = count_o;
    delta(16'h0004);
    bus(1'b1, TIMER_CTRL_OFS, DAT_ZERO);
    bus(1'b1, GATE_CTRL_OFS, 32'h0000_0080);
    c0 = count_o;
    delta(16'h0000);
    bus(1'b1, TIMER_CTRL_OFS, 32'h0000_0001);
  endtask
  // polarity and gate level in all four pairs, gate enable on and off
  task automatic s_level;
    for (int i = 0; i < 4; i++)
    begin
      gate_src_inst.set(i[1]);
      bus(1'b1, GATE_CTRL_OFS, {24'h0, ~i[1], i[0], 6'h00});
      bus(1'b0, GATE_CTRL_OFS, DAT_ZERO);
      chk(q & 32'h4, {29'h0, i[1] ~^ i[0], 2'h0});
    end
    gate_src_inst.set(1'b0);
  endtask
  task automatic s_toggle;
    bus(1'b1, GATE_CTRL_OFS, 32'h0000_00E0);
    for (int i = 1; i < 4; i++)
    begin
      gate_src_inst.pulse(2);
      bus(1'b0, GATE_CTRL_OFS, DAT_ZERO);
      chk(q & 32'h4, {29'h0, i[0], 2'h0});
    end
    bus(1'b1, GATE_CTRL_OFS, 32'h0000_00C0);
    bus(1'b1, GATE_CTRL_OFS, 32'h0000_00E0);
    bus(1'b0, GATE_CTRL_OFS, DAT_ZERO);
    chk(q & 32'h4, DAT_ZERO);
  endtask
  task automatic s_single;
    bus(1'b1, IRQ_MASK_OFS, DAT_ZERO);
    bus(1'b1, IRQ_STAT_OFS, 32'h0000_0003);
    bus(1'b1, GATE_CTRL_OFS, 32'h0000_00D8);
    bus(1'b0, GATE_CTRL_OFS, DAT_ZERO);
    chk(q & 32'h8, 32'h8);
    c0 = count_o;
    gate_src_inst.pulse(3);
    delta(16'h0003);
    bus(1'b0, GATE_CTRL_OFS, DAT_ZERO);
    chk(q & 32'h8, DAT_ZERO);
    bus(1'b0, IRQ_STAT_OFS, DAT_ZERO);
    chk(q, 32'h1);
    chk({31'h0, irq_o}, DAT_ZERO);
    bus(1'b1, IRQ_MASK_OFS, 32'h1);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b1, IRQ_STAT_OFS, 32'h1);
    @(posedge clk_i);
    chk({31'h0, irq_o}, DAT_ZERO);
    c0 = count_o;
    gate_src_inst.pulse(3);
    delta(16'h0000);
  endtask
  // arm, then drop the mode while writing the arm bit as one
  task automatic s_cancel;
    bus(1'b1, GATE_CTRL_OFS, 32'h0000_00D8);
    bus(1'b1, GATE_CTRL_OFS, 32'h0000_00C8);
    bus(1'b0, GATE_CTRL_OFS, DAT_ZERO);
    chk(q & 32'h8, DAT_ZERO);
    c0 = count_o;
    gate_src_inst.pulse(3);
    gate_src_inst.pulse(3);
    delta(16'h0006);
  endtask
  // byte lanes, overflow interrupt and a power-on reset in mid-run
  task automatic s_count;
    bus(1'b1, TIMER_CTRL_OFS, DAT_ZERO);
    sel_i <= 4'h1;
    bus(1'b1, COUNT_OFS, 32'h0000_12FE);
    sel_i <= 4'h2;
    bus(1'b1, COUNT_OFS, 32'h0000_FF34);
    sel_i <= 4'h0;
    bus(1'b1, GATE_CTRL_OFS, DAT_ZERO);
    sel_i <= 4'hF;
    bus(1'b0, GATE_CTRL_OFS, DAT_ZERO);
    chk(q & 32'hFFFF_FFFB, 32'h0000_00C0);
    bus(1'b0, COUNT_OFS, DAT_ZERO);
    chk(q, 32'h0000_FFFE);
    bus(1'b1, GATE_CTRL_OFS, DAT_ZERO);
    bus(1'b1, IRQ_MASK_OFS, 32'h0000_0002);
    bus(1'b1, TIMER_CTRL_OFS, 32'h0000_0001);
    bus(1'b0, IRQ_STAT_OFS, DAT_ZERO);
    chk(q, 32'h0000_0002);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b1, IRQ_STAT_OFS, 32'h0000_0002);
    chk({31'h0, irq_o}, DAT_ZERO);
    @(posedge clk_i);
    por_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    por_i <= 1'b0;
    bus(1'b0, GATE_CTRL_OFS, DAT_ZERO);
    chk(q & 32'hFFFF_FFFB, DAT_ZERO);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // whole run is a few hundred cycles
  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    end_sim;
  end
  initial
  begin
    rst_i = 1'b1;
    por_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hF;
    dat_i = DAT_ZERO;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    s_regs;
    s_free;
    s_level;
    s_toggle;
    s_single;
    s_cancel;
    s_count;
    end_sim;
  end
endmodule // timer_gate_top_tb
